/* hdl/spi_msg_defs.svh */
// Purpose: Shared constants of the SPI slave message port
// Assumes: Included by the package and by the design module
// Notes:   Timing counts are derived from the 100 MHz reference clock
`ifndef SPI_MSG_DEFS_SVH
`define SPI_MSG_DEFS_SVH
// ----------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------
`define STAT_RX_READY_BIT 0
`define STAT_TX_QUEUED_BIT 1
`define STAT_RSVD_HI 7
`define STAT_RSVD_LO 2
// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define BUF_ADDR_W 6
`define WORD_W 32
`define BYTE_W 8
`define PAD_BYTE 8'h00
`define LEN_RESET 8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define REF_CLK_PERIOD_NS 10
`define SEL_GAP_NS 400
`define SEL_GAP_CYCLES ((`SEL_GAP_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`endif

/* hdl/spi_msg_pkg.sv */
// Purpose: Types of the SPI slave message port
// Assumes: spi_msg_defs.svh gives the sizes
// Notes:   Holds the link phase enum and the receive buffer entry
`include "spi_msg_defs.svh"
package spi_msg_pkg;
  // ----------------------------------------------------------------
  // Link phase, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_STAT = 5'b00010,
    PH_PAD  = 5'b00100,
    PH_LEN  = 5'b01000,
    PH_DATA = 5'b10000
  } phase_t;
  // Received word on its way to memory
  typedef struct packed {
    logic                   bufSel;
    logic [`BUF_ADDR_W-1:0] addr;
    logic [`WORD_W-1:0]     data;
  } rx_entry_t;
endpackage

/* hdl/spi_msg_slave.sv */
// Purpose: SPI slave message port with two on-chip message buffers
// Assumes: SPI mode 0 (sample on rising, shift on falling); select active low
// Notes:   Link pins are oversampled by ref_clk; serial clock must stay well below 25 MHz
//
// Functional notes
// [RQ1] Status bit 0 says a receive buffer is free.
// [RQ2] Status bit 1 says a message is queued; bits 7..2 send zero.
// [RQ3] Device sends padding then status while master sends status then padding.
// [RQ4] Master frames each transaction with select asserted low.
// [RQ5] Output released while unselected; bytes go most significant bit first.
// [RQ6] Queued message and partner ready: send length in words next.
// [RQ7] Nothing to send or not allowed: length byte is zero.
// [RQ8] Master may stop after status and padding when nothing can move.
// [RQ9] Nonzero length streams transmit buffer and fills receive buffer from start.
// [RQ10] Master clocks until the longer direction has finished.
// [RQ11] Words move in ascending address order, most significant bit first.
// [RQ12] Master keeps select high at least 400 ns between transactions.
// [RQ13] First payload word holds count minus one in its low byte.
// [RQ14] Hardware builds and decodes status, padding and length bytes.
// [RQ15] Software loads a buffer, then posts buffer and length; attention rises.
// [RQ16] Attention drops as soon as a transaction begins.
// [RQ17] Message unsent at transaction end: attention rises again.
// [RQ18] Maskable completion interrupt when select rises after a start.
// [RQ19] Receive ready shows only after software arms reception.
// [RQ20] Attention when armed after master earlier found receive not ready.
// [RQ21] Concurrent transmit and receive buffers must differ.
// [RQ22] Writing master stops when device shows not ready, unless receiving.
// [RQ23] Ready device: master sends length byte then all announced words.
// [RQ24] Reading master checks queued flag, then clocks length and data.
// [RQ25] Select rising mid-word discards the partial word and ends there.
`timescale 1ns/100ps
`include "spi_msg_defs.svh"
module spi_msg_slave
  import spi_msg_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
)(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   serialClock,
  input  wire logic                   serialIn,
  input  wire logic                   peripheralSelectN,
  output logic                        serialOut,
  output logic                        serialOutEn,
  output logic                        hostAttention,
  input  wire logic                   swWrite,
  input  wire logic                   swBuf,
  input  wire logic [`BUF_ADDR_W-1:0] swAddr,
  input  wire logic [`WORD_W-1:0]     swWrData,
  output logic      [`WORD_W-1:0]     swRdData,
  input  wire logic                   txPost,
  input  wire logic                   txPostBuf,
  input  wire logic [`BYTE_W-1:0]     txPostLen,
  output logic                        txPending,
  input  wire logic                   rxArm,
  input  wire logic                   rxArmBuf,
  output logic                        rxArmed,
  output logic                        rxDone,
  output logic      [`BYTE_W-1:0]     rxLen,
  input  wire logic                   doneClear,
  input  wire logic                   doneIrqEnable,
  output logic                        doneIrq,
  output logic                        rxOverrun
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] sclkSync_r, selSync_r, sinSync_r;
  logic       sclkDly_r, selDly_r;
  // Edges look only at the second stage and its delayed copy
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      sclkSync_r <= 2'h0;
      selSync_r  <= 2'h3;
      sinSync_r  <= 2'h0;
      sclkDly_r  <= 1'h0;
      selDly_r   <= 1'h1;
    end
    else
    begin
      sclkSync_r <= {sclkSync_r[0], serialClock};
      selSync_r  <= {selSync_r[0], peripheralSelectN};
      sinSync_r  <= {sinSync_r[0], serialIn};
      sclkDly_r  <= sclkSync_r[1];
      selDly_r   <= selSync_r[1];
    end

  logic active, selStart, selEnd, sclkRise, sclkFall, sinBit;
  assign active   = !selSync_r[1];
  assign selStart = !selSync_r[1] && selDly_r;  // [RQ4]
  assign selEnd   = selSync_r[1] && !selDly_r;
  assign sclkRise = active && sclkSync_r[1] && !sclkDly_r;
  assign sclkFall = active && !sclkSync_r[1] && sclkDly_r;
  assign sinBit   = sinSync_r[1];

  // ----------------------------------------------------------------
  // Message memory: two buffers of 2**BUF_ADDR_W words
  // ----------------------------------------------------------------
  logic [`WORD_W-1:0] mem [2][2**`BUF_ADDR_W];
  rx_entry_t          fifoMem [FIFO_DEPTH];
  logic [$clog2(FIFO_DEPTH):0] fifoCnt_r;
  logic [$clog2(FIFO_DEPTH)-1:0] fifoWr_r, fifoRd_r;
  logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  rx_entry_t fifoIn;
  assign fifoInReady  = (fifoCnt_r != ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH));
  assign fifoOutValid = (fifoCnt_r != '0);
  assign fifoOutReady = !swWrite;  // Software writes stall the drain

  // Memory write: software first, then received words from the buffer
  always_ff @(posedge ref_clk)
    if (swWrite)
      mem[swBuf][swAddr] <= swWrData;
    else if (fifoOutValid)
      mem[fifoMem[fifoRd_r].bufSel][fifoMem[fifoRd_r].addr] <= fifoMem[fifoRd_r].data;  // [RQ9]

  // Two-entry buffer absorbs stalls of the memory port
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      fifoCnt_r <= '0;
      fifoWr_r  <= '0;
      fifoRd_r  <= '0;
    end
    else
    begin
      if (fifoInValid && fifoInReady)
        fifoWr_r <= fifoWr_r + 1'b1;
      if (fifoOutValid && fifoOutReady)
        fifoRd_r <= fifoRd_r + 1'b1;
      fifoCnt_r <= fifoCnt_r + (($clog2(FIFO_DEPTH)+1)'(fifoInValid && fifoInReady))
                 - (($clog2(FIFO_DEPTH)+1)'(fifoOutValid && fifoOutReady));
    end

  always_ff @(posedge ref_clk)
    if (fifoInValid && fifoInReady)
      fifoMem[fifoWr_r] <= fifoIn;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      swRdData <= '0;
    else
      swRdData <= mem[swBuf][swAddr];

  // ----------------------------------------------------------------
  // Link sequencing
  // ----------------------------------------------------------------
  phase_t             phase_r;
  logic [4:0]         bitCnt_r;
  logic [`WORD_W-1:0] inShift_r, outShift_r, nextOut_r;
  logic               loadPending_r, sending_r, receiving_r;
  logic [`BYTE_W-1:0] txLen_r, outLen_r, inLen_r, wordCnt_r;
  logic               txBuf_r, rxBuf_r, rxWanted_r, doneFlag_r;
  logic               unitLast, unitDone;
  logic [`WORD_W-1:0] inWord, txWord;
  logic [`BYTE_W-1:0] lenOut;

  assign unitLast = (phase_r == PH_DATA) ? (bitCnt_r == 5'h1f) : (bitCnt_r == 5'h07);
  assign unitDone = sclkRise && unitLast;
  assign inWord   = {inShift_r[`WORD_W-2:0], sinBit};
  // Length only when queued and partner ready, else zero
  assign lenOut   = (txPending && inWord[`STAT_RX_READY_BIT]) ? txLen_r : `LEN_RESET;  // [RQ6] [RQ7]
  assign txWord   = mem[txBuf_r][wordCnt_r[`BUF_ADDR_W-1:0]];  // [RQ11]
  // Received word goes to the buffer only while the announced count lasts
  assign fifoInValid = unitDone && (phase_r == PH_DATA) && receiving_r && (wordCnt_r < inLen_r);  // [RQ9] [RQ25]
  assign fifoIn      = '{bufSel: rxBuf_r, addr: wordCnt_r[`BUF_ADDR_W-1:0], data: inWord};

  // Phase, bit count and incoming shift; phase and bit count restart on each select, the shift does not
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      phase_r   <= PH_IDLE;
      bitCnt_r  <= 5'h00;
      inShift_r <= '0;
    end
    else if (!active)
    begin
      phase_r  <= PH_IDLE;  // [RQ25]
      bitCnt_r <= 5'h00;
    end
    else if (selStart)
      phase_r <= PH_STAT;
    else if (sclkRise)
    begin
      inShift_r <= inWord;
      bitCnt_r  <= unitLast ? 5'h00 : bitCnt_r + 5'h01;
      if (unitLast)
      begin
        unique case (phase_r)
          PH_IDLE: phase_r <= PH_STAT;
          PH_STAT: phase_r <= PH_PAD;
          PH_PAD:  phase_r <= PH_LEN;
          PH_LEN:  phase_r <= PH_DATA;
          PH_DATA: phase_r <= PH_DATA;
        endcase
      end
    end

  // Decoding of master bytes and choice of the next outgoing unit
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      nextOut_r       <= '0;
      loadPending_r   <= 1'h0;
      sending_r       <= 1'h0;
      receiving_r     <= 1'h0;
      outLen_r        <= `LEN_RESET;
      inLen_r         <= `LEN_RESET;
      wordCnt_r       <= 8'h00;
    end
    else if (selStart)
    begin
      // A select cut right after a unit must not load a stale unit next time
      loadPending_r <= 1'h0;  // [RQ25]
      sending_r   <= 1'h0;
      receiving_r <= 1'h0;
      outLen_r    <= `LEN_RESET;
      inLen_r     <= `LEN_RESET;
      wordCnt_r   <= 8'h00;
    end
    else if (unitDone)
    begin
      loadPending_r <= 1'h1;
      unique case (phase_r)
        PH_STAT:
        begin
          // Hardware builds the status byte; reserved bits zero
          nextOut_r <= {6'h00, txPending, rxArmed, 24'h000000};  // [RQ1] [RQ2] [RQ3] [RQ14] [RQ19]
          outLen_r  <= lenOut;
          sending_r <= (lenOut != `LEN_RESET);
        end
        PH_PAD:
          nextOut_r <= {outLen_r, 24'h000000};  // [RQ3] [RQ6]
        PH_LEN:
        begin
          inLen_r     <= inWord[`BYTE_W-1:0];
          receiving_r <= rxArmed && (inWord[`BYTE_W-1:0] != `LEN_RESET);
          nextOut_r   <= sending_r ? txWord : '0;  // [RQ9] [RQ13]
        end
        PH_DATA:
        begin
          wordCnt_r <= wordCnt_r + 8'h01;  // [RQ11]
          nextOut_r <= (sending_r && (wordCnt_r + 8'h01 < outLen_r))
                       ? mem[txBuf_r][wordCnt_r[`BUF_ADDR_W-1:0] + 6'h01] : '0;
        end
        default:
          nextOut_r <= '0;
      endcase
    end
    else if (sclkFall)
      loadPending_r <= 1'h0;

  // Outgoing shift: padding first, new unit on the falling edge after a unit
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      outShift_r  <= '0;
      serialOut   <= 1'h0;
      serialOutEn <= 1'h0;
    end
    else
    begin
      serialOutEn <= active;  // [RQ5]
      if (selStart)
        outShift_r <= {`PAD_BYTE, 24'h000000};  // [RQ3]
      else if (sclkFall)
        outShift_r <= loadPending_r ? nextOut_r : {outShift_r[`WORD_W-2:0], 1'b0};
      serialOut <= (sclkFall && loadPending_r) ? nextOut_r[`WORD_W-1] :
                   sclkFall ? outShift_r[`WORD_W-2] : selStart ? 1'b0 : serialOut;  // [RQ5] [RQ11]
    end

  // ----------------------------------------------------------------
  // Software side: posting, arming, completion
  // ----------------------------------------------------------------
  logic txSent, rxComplete;
  assign txSent     = selEnd && sending_r && (wordCnt_r >= outLen_r);
  assign rxComplete = selEnd && receiving_r && (wordCnt_r >= inLen_r);

  // Posting is refused while the buffer is armed for reception
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      txPending <= 1'h0;
      txBuf_r   <= 1'h0;
      txLen_r   <= `LEN_RESET;
    end
    else if (txPost && !txPending && !(rxArmed && rxBuf_r == txPostBuf))
    begin
      txPending <= 1'h1;  // [RQ15] [RQ21]
      txBuf_r   <= txPostBuf;
      txLen_r   <= txPostLen;
    end
    else if (txSent)
      txPending <= 1'h0;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      rxArmed <= 1'h0;
      rxBuf_r <= 1'h0;
      rxDone  <= 1'h0;
      rxLen   <= `LEN_RESET;
    end
    else if (rxArm && !(txPending && txBuf_r == rxArmBuf))
    begin
      rxArmed <= 1'h1;  // [RQ19] [RQ21]
      rxBuf_r <= rxArmBuf;
      rxDone  <= rxComplete;  // A completion in the same cycle beats the clear
      rxLen   <= rxComplete ? inLen_r : rxLen;
    end
    else if (rxComplete)
    begin
      rxArmed <= 1'h0;
      rxDone  <= 1'h1;
      rxLen   <= inLen_r;
    end

  // Master tried to send while not armed; set wins over the clear
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      rxWanted_r <= 1'h0;
    else if (unitDone && phase_r == PH_STAT && inWord[`STAT_TX_QUEUED_BIT] && !rxArmed)
      rxWanted_r <= 1'h1;
    else if (selStart && rxArmed)
      rxWanted_r <= 1'h0;

  // Attention is held low throughout a transaction
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      hostAttention <= 1'h0;
    else
      hostAttention <= !active && !selEnd && (txPending || (rxWanted_r && rxArmed));  // [RQ15] [RQ16] [RQ17] [RQ20]

  // Completion flag; a new completion beats a clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
      doneFlag_r <= 1'h0;
    else if (selEnd)
      doneFlag_r <= 1'h1;  // [RQ18]
    else if (doneClear)
      doneFlag_r <= 1'h0;

  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      doneIrq   <= 1'h0;
      rxOverrun <= 1'h0;
    end
    else
    begin
      doneIrq <= doneFlag_r && doneIrqEnable;  // [RQ18]
      if (fifoInValid && !fifoInReady)
        rxOverrun <= 1'h1;
      else if (rxArm)
        rxOverrun <= 1'h0;
    end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence statDoneSeq;
    unitDone && phase_r == PH_STAT;
  endsequence

  attn_drop_a: assert property (selStart |=> !hostAttention [*3]) else $error("attention during transaction"); // [RQ16]
  oe_idle_a: assert property (!active |=> !serialOutEn) else $error("output driven while idle"); // [RQ5]
  status_fmt_a: assert property (statDoneSeq |=> nextOut_r[31:26] == 6'h00
    && nextOut_r[25] == $past(txPending) && nextOut_r[24] == $past(rxArmed)) else $error("bad status byte"); // [RQ1]
  len_zero_a: assert property (statDoneSeq and !txPending |=> outLen_r == 8'h00) else $error("length not zero"); // [RQ7]
  len_value_a: assert property (statDoneSeq and (txPending && sinBit)
    |=> outLen_r == $past(txLen_r)) else $error("length mismatch"); // [RQ6]
  tx_clear_a: assert property (txSent |=> !txPending) else $error("sent message still pending"); // [RQ15]
  attn_back_a: assert property (selEnd && txPending && !txSent |=> ##[0:2] hostAttention)
    else $error("attention not restored"); // [RQ17]
  done_set_a: assert property (selEnd |=> doneFlag_r ##1 (doneIrq == doneIrqEnable)) else $error("completion lost"); // [RQ18]
  buf_diff_a: assert property (txPending && rxArmed |-> txBuf_r != rxBuf_r) else $error("shared buffer"); // [RQ21]
  msb_shift_a: assert property (sclkFall && !loadPending_r |=> serialOut == $past(outShift_r[30]))
    else $error("bit order wrong"); // [RQ11]
endmodule

/* test/spi_master_model.sv */
// Purpose: Behavioural SPI master standing on the far side of the message port
// Assumes: Mode 0, clock idle low, select active low, 160 ns serial clock period
// Notes:   Emits every device byte it interprets through rxByte and rxCount
`timescale 1ns/100ps
module spi_master_model
(
  input  wire logic ref_clk,
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi,
  output logic      selN,
  output logic [7:0] rxByte,
  output int        rxCount
);
  logic [31:0] txWords [0:63];
  logic [7:0]  devStat;
  logic [7:0]  devLen;

  // Idle levels: released select, clock low
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b0;
    selN = 1'b1;
    rxCount = 0;
  end

  // Half a serial clock period, 8 reference cycles
  task automatic halfBit();
    repeat (8) @(negedge ref_clk);
  endtask

  // One byte both ways, most significant bit first
  task automatic shiftByte(input logic [7:0] tx, input bit emit, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--)
    begin
      mosi = tx[b];
      halfBit();
      sclk = 1'b1;
      rx[b] = miso;
      halfBit();
      sclk = 1'b0;
    end
    if (emit)
    begin
      rxByte = rx;
      rxCount++;
    end
  endtask

  // One transaction; maxBytes below zero clocks all payload, else stops early
  task automatic transact(input logic [7:0] mStat, input logic [7:0] mLen, input int maxBytes);
    logic [7:0] r;
    int         sendLen;
    int         n;
    selN = 1'b0;
    halfBit();
    shiftByte(mStat, 1'b0, r);
    shiftByte(8'h00, 1'b1, devStat);
    // Stop after the padding byte when nothing can move
    if ((mStat[1] && devStat[0]) || (mStat[0] && devStat[1]))
    begin
      sendLen = devStat[0] ? int'(mLen) : 0;
      shiftByte(sendLen[7:0], 1'b1, devLen);
      n = (sendLen > int'(devLen)) ? sendLen : int'(devLen);
      for (int j = 0; j < 4 * n && (maxBytes < 0 || j < maxBytes); j++)
        shiftByte((j / 4 < sendLen) ? txWords[j / 4][8 * (3 - j % 4) +: 8] : 8'h00,
                  j / 4 < int'(devLen), r);
    end
    halfBit();
    selN = 1'b1;
    mosi = 1'b0;
    // Gap of 480 ns keeps clear of the 400 ns minimum
    repeat (48) @(negedge ref_clk);
  endtask
endmodule

/* test/testbench.sv */
// Purpose: Self-checking bench of the SPI slave message port
// Assumes: Link bytes are checked in order by a monitor fed from a queue
// Notes:   Released serial output shows the inverse of its last driven value
`timescale 1ns/100ps
`include "spi_msg_defs.svh"
module testbench
  import spi_msg_pkg::*;
;
  logic ref_clk = 1'b0, reset = 1'b1, lastOut = 1'b0;
  logic sclk, mosi, selN, swWrite, swBuf, txPost, txPostBuf, rxArm, rxArmBuf, doneClear, doneIrqEnable;
  logic [`BUF_ADDR_W-1:0] swAddr;
  logic [`WORD_W-1:0]     swWrData, swRdData, rd;
  logic [`BYTE_W-1:0]     txPostLen, rxLen, rxByte;
  logic serialOut, serialOutEn, hostAttention, txPending, rxArmed, rxDone, doneIrq, rxOverrun, miso;
  logic [31:0] w [0:3];
  logic [7:0]  expQ [$];
  logic        txBuf;
  int rxCount, fails = 0, nTests = 0, seed = 82, nw;

  // ----------------------------------------------------------------
  // Clock, instances and the resolved serial output
  // ----------------------------------------------------------------
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (serialOutEn) lastOut <= serialOut;
  assign miso = serialOutEn ? serialOut : ~lastOut;
  spi_master_model spi_master_model_i (.ref_clk(ref_clk), .miso(miso), .sclk(sclk), .mosi(mosi),
    .selN(selN), .rxByte(rxByte), .rxCount(rxCount));
  spi_msg_slave spi_msg_slave_i (.ref_clk(ref_clk), .reset(reset), .serialClock(sclk), .serialIn(mosi),
    .peripheralSelectN(selN), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .hostAttention(hostAttention), .swWrite(swWrite), .swBuf(swBuf), .swAddr(swAddr),
    .swWrData(swWrData), .swRdData(swRdData), .txPost(txPost), .txPostBuf(txPostBuf),
    .txPostLen(txPostLen), .txPending(txPending), .rxArm(rxArm), .rxArmBuf(rxArmBuf),
    .rxArmed(rxArmed), .rxDone(rxDone), .rxLen(rxLen), .doneClear(doneClear),
    .doneIrqEnable(doneIrqEnable), .doneIrq(doneIrq), .rxOverrun(rxOverrun));

  // ----------------------------------------------------------------
  // Comparison, verdict and byte monitor
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic endOfTest();
    if (expQ.size() != 0) fails++;
    if (fails == 0 && nTests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // An unexpected byte is compared against a value it can never match
  always @(rxCount)
  begin
    if (expQ.size() == 0)
      check(32'hxxxx_xxxx, {24'h0, rxByte});
    else
      check({24'h0, rxByte}, {24'h0, expQ.pop_front()});
  end
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    endOfTest();
  end

  // ----------------------------------------------------------------
  // Software side tasks, all driven at the falling edge
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic swWr(input logic b, input logic [5:0] a, input logic [31:0] d);
    cyc(1);
    swWrite = 1'b1;
    swBuf = b;
    swAddr = a;
    swWrData = d;
    cyc(1);
    swWrite = 1'b0;
  endtask
  task automatic swRd(input logic b, input logic [5:0] a);
    cyc(1);
    swBuf = b;
    swAddr = a;
    cyc(2);
    rd = swRdData;
  endtask
  task automatic post(input logic b, input logic [7:0] n);
    cyc(1);
    txPost = 1'b1;
    txPostBuf = b;
    txPostLen = n;
    cyc(1);
    txPost = 1'b0;
  endtask
  task automatic arm(input logic b);
    cyc(1);
    rxArm = 1'b1;
    rxArmBuf = b;
    cyc(1);
    rxArm = 1'b0;
  endtask
  task automatic expW(input logic [31:0] v);
    for (int k = 3; k >= 0; k--) expQ.push_back(v[8 * k +: 8]);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {swWrite, swBuf, swAddr, swWrData, txPost, txPostBuf, txPostLen} = '0;
    {rxArm, rxArmBuf, doneClear, doneIrqEnable} = '0;
    repeat (8) @(posedge ref_clk);
    cyc(1);
    reset = 1'b0;
    // Random buffer, word count and interrupt mask for this run
    rd = $random(seed);
    doneIrqEnable = rd[2];
    txBuf = rd[0];
    nw = 2 + int'(rd[1]);
    check({txPending, rxArmed, hostAttention, serialOutEn, doneIrq}, 5'h00);
    // Nothing either way: status only, then completion flag and its clear
    cyc(4);
    expQ.push_back(8'h00);
    spi_master_model_i.transact(8'h00, 8'h00, -1);
    check(doneIrq, doneIrqEnable);
    cyc(1);
    doneClear = 1'b1;
    cyc(1);
    doneClear = 1'b0;
    cyc(2);
    check(doneIrq, 1'b0);
    // Device sends two or three words from the random buffer
    w[0] = 32'(nw - 1);
    for (int i = 1; i < nw; i++)
      w[i] = $random(seed);
    for (int i = 0; i < nw; i++)
      swWr(txBuf, i[5:0], w[i]);
    post(txBuf, nw[7:0]);
    cyc(1);
    check({txPending, hostAttention}, 2'b11);
    expQ.push_back(8'h02);
    expQ.push_back(nw[7:0]);
    for (int i = 0; i < nw; i++)
      expW(w[i]);
    fork
      spi_master_model_i.transact(8'h01, 8'h00, -1);
      begin
        cyc(12);
        check({hostAttention, serialOutEn}, 2'b01);
      end
    join
    check({txPending, hostAttention, serialOutEn}, 3'b000);
    // Master write refused, then armed: attention, then two words land in the other buffer
    spi_master_model_i.txWords[0] = 32'h0000_0001;
    spi_master_model_i.txWords[1] = $random(seed);
    expQ.push_back(8'h00);
    spi_master_model_i.transact(8'h02, 8'h02, -1);
    check(hostAttention, 1'b0);
    arm(~txBuf);
    cyc(2);
    check({rxArmed, hostAttention}, 2'b11);
    expQ.push_back(8'h01);
    expQ.push_back(8'h00);
    spi_master_model_i.transact(8'h02, 8'h02, -1);
    check({rxDone, rxLen}, 9'h102);
    for (int i = 0; i < 2; i++)
    begin
      swRd(~txBuf, i[5:0]);
      check(rd, spi_master_model_i.txWords[i]);
    end
    // Both ways at once, cut off in mid-word: message stays pending
    w[0] = 32'h0000_0001;
    w[1] = $random(seed);
    swWr(txBuf, 6'h00, w[0]);
    swWr(txBuf, 6'h01, w[1]);
    post(txBuf, 8'h02);
    arm(txBuf);
    cyc(2);
    check(rxArmed, 1'b0);
    arm(~txBuf);
    cyc(2);
    check(rxArmed, 1'b1);
    spi_master_model_i.txWords[0] = 32'h0000_0000;
    expQ.push_back(8'h03);
    expQ.push_back(8'h02);
    expW(w[0]);
    expQ.push_back(w[1][31:24]);
    expQ.push_back(w[1][23:16]);
    spi_master_model_i.transact(8'h03, 8'h01, 6);
    check({txPending, hostAttention, rxDone, rxLen, rxOverrun}, 12'he02);
    swRd(~txBuf, 6'h00);
    check(rd, 32'h0000_0000);
    // Retry completes the message; completion interrupt is now masked
    doneIrqEnable = 1'b0;
    expQ.push_back(8'h02);
    expQ.push_back(8'h02);
    expW(w[0]);
    expW(w[1]);
    spi_master_model_i.transact(8'h01, 8'h00, -1);
    check({txPending, hostAttention, doneIrq}, 3'b000);
    endOfTest();
  end
endmodule
